// *** verilog/rsfe_pkg.sv ***
// Constants, register map and carrier types of the raw serial frame engine
// Overview of operation
// [RL1] A send starts only on a low-to-high change of the send trigger, never while it merely stays high.
// [RL2] Software loads the outgoing bytes and their frame definition before it raises the send trigger.
// [RL3] A send emits exactly the defined byte count, starting at the defined base of the storage area.
// [RL4] Received bytes reach the destination area only after the end-of-frame condition is met.
// [RL5] The format word's upper byte selects the end mode, 00 count and 01 terminator; its lower byte is the value.
// [RL6] In count mode a frame closes when the received count equals the lower byte, valid from 1 to 255.
// [RL7] In terminator mode a frame closes on the configured ending byte, so back-to-back frames separate.
// [RL8] Bytes that do not fit the configured format are discarded and never written to the destination.
// [RL9] A completed frame sets the receive done bit in the receive status.
// [RL10] With the done bit the receive status shows the frame length in bytes.
// [RL11] The error flag rises when a designated area reaches past the end of the storage range.
// [RL12] Frames are defined per command from a table of up to 128 definitions.
// [RL13] After a frame the byte counter clears and collection of the next frame resumes.
package rsfe_pkg;

    // Sizes
    localparam int unsigned MEM_BYTES = 256;
    localparam int unsigned FRAME_SLOTS = 128;
    localparam int unsigned FRAME_MAX = 255;

    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_RX_FMT = 12'h004;
    localparam logic [11:0] OFS_RX_BASE = 12'h008;
    localparam logic [11:0] OFS_TX_STAT = 12'h00C;
    localparam logic [11:0] OFS_RX_STAT = 12'h010;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h014;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h018;

    // Address regions: registers, definition table, storage window
    localparam logic [2:0] REGION_REG = 3'h0;
    localparam logic [2:0] REGION_DEF = 3'h1;
    localparam logic [1:0] REGION_MEM = 2'h1;

    // End modes of the receive format word
    localparam logic [7:0] END_BY_COUNT = 8'h00;
    localparam logic [7:0] END_BY_TERM = 8'h01;

    // Interrupt and status bit positions
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_TX_DONE = 0;
    localparam int unsigned IRQ_RX_DONE = 1;
    localparam int unsigned IRQ_ERR = 2;

    // Reset values
    localparam logic [15:0] RX_FMT_RST = 16'h0103;
    localparam logic [7:0] RX_BASE_RST = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    // Control register: send trigger bit 0, receive enable bit 1, slot in 14:8
    typedef struct packed {
        logic [6:0] slot;
        logic [5:0] pad;
        logic rx_en;
        logic send;
    } rsfe_ctrl_t;

    // One frame definition: storage base and byte count
    typedef struct packed {
        logic [7:0] base;
        logic [7:0] len;
    } rsfe_def_t;

    // Receive format word
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] value;
    } rsfe_fmt_t;

    // Status word: length 15:8, busy 2, error 1, done 0
    typedef struct packed {
        logic [7:0] len;
        logic [4:0] pad;
        logic busy;
        logic err;
        logic done;
    } rsfe_stat_t;

endpackage

// *** verilog/rsfe_rx.sv ***
// Receive framer: collects bytes and closes frames by count or terminator
module rsfe_rx #(
    parameter int unsigned FRAME_MAX = rsfe_pkg::FRAME_MAX
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire logic enable,
    input wire rsfe_pkg::rsfe_fmt_t fmt,
    // Incoming byte stream
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    // Frame buffer read port
    input wire logic [7:0] rd_idx,
    output logic [7:0] rd_data,
    // Frame events
    output logic frame_done,
    output logic [7:0] frame_len,
    output logic fmt_bad
);

    if (FRAME_MAX < 1 || FRAME_MAX > 255) begin : g_bad_max
        $error("rsfe_rx: FRAME_MAX must lie in 1..255");
    end

    logic [7:0] frame_buf [FRAME_MAX];
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic next_frame_done;
    logic [7:0] next_frame_len;
    logic next_fmt_bad;
    logic buf_we;
    logic fmt_ok;
    logic [7:0] cnt_inc;
    logic is_count;
    logic is_term;

    // Next-state logic of the collector
    always_comb begin
        next_cnt = cnt;
        next_frame_done = 1'b0;
        next_frame_len = frame_len;
        next_fmt_bad = 1'b0;
        buf_we = 1'b0;
        is_count = fmt.mode == rsfe_pkg::END_BY_COUNT; // RL5
        is_term = fmt.mode == rsfe_pkg::END_BY_TERM; // RL5
        fmt_ok = (is_count && fmt.value != 8'h00) || is_term; // RL6
        cnt_inc = cnt + 8'h01;
        if (!enable) begin
            next_cnt = 8'h00;
        end else if (rx_valid) begin
            if (!fmt_ok) begin
                next_fmt_bad = 1'b1; // RL8
                next_cnt = 8'h00;
            end else begin
                buf_we = 1'b1;
                if ((is_count && cnt_inc == fmt.value) || (is_term && rx_data == fmt.value)) begin // RL6 RL7
                    next_frame_done = 1'b1;
                    next_frame_len = cnt_inc;
                    next_cnt = 8'h00; // RL13
                end else if (cnt_inc == 8'(FRAME_MAX)) begin
                    next_fmt_bad = 1'b1; // RL8
                    next_cnt = 8'h00;
                end else begin
                    next_cnt = cnt_inc;
                end
            end
        end
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            frame_done <= 1'b0;
            frame_len <= 8'h00;
            fmt_bad <= 1'b0;
        end else begin
            cnt <= next_cnt;
            frame_done <= next_frame_done;
            frame_len <= next_frame_len;
            fmt_bad <= next_fmt_bad;
        end
    end

    // Frame buffer write; bytes of the next frame overwrite it even while the copy engine is still moving it
    always_ff @(posedge clk) begin
        if (buf_we) begin
            frame_buf[cnt] <= rx_data; // RL4
        end
    end

    assign rd_data = frame_buf[rd_idx];

endmodule

// *** verilog/rsfe_top.sv ***
// Raw serial frame engine: APB registers, storage, send engine and receive copy engine
module rsfe_top #(
    parameter int unsigned MEM_BYTES = rsfe_pkg::MEM_BYTES,
    parameter int unsigned FRAME_SLOTS = rsfe_pkg::FRAME_SLOTS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Outgoing byte stream
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    // Incoming byte stream
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    // Interrupt
    output logic irq
);

    if (MEM_BYTES < 1 || MEM_BYTES > 256 || FRAME_SLOTS < 1 || FRAME_SLOTS > 128) begin : g_bad_size
        $error("rsfe_top: MEM_BYTES must lie in 1..256 and FRAME_SLOTS in 1..128");
    end

    localparam logic [8:0] MEM_LIMIT = 9'(MEM_BYTES);
    localparam logic [7:0] SLOT_LIMIT = 8'(FRAME_SLOTS);

    typedef enum logic {TX_IDLE, TX_SEND} rsfe_tx_state_t;
    typedef enum logic {CP_IDLE, CP_COPY} rsfe_cp_state_t;

    // Storage and frame definition table
    logic [7:0] mem [MEM_BYTES];
    rsfe_pkg::rsfe_def_t defs [FRAME_SLOTS];

    // Register group
    rsfe_pkg::rsfe_ctrl_t ctrl, next_ctrl;
    rsfe_pkg::rsfe_fmt_t rx_fmt, next_rx_fmt;
    logic [7:0] rx_base, next_rx_base;
    rsfe_pkg::rsfe_stat_t tx_stat, next_tx_stat;
    rsfe_pkg::rsfe_stat_t rx_stat, next_rx_stat;
    logic [rsfe_pkg::IRQ_W-1:0] irq_stat, next_irq_stat;
    logic [rsfe_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;
    logic [31:0] next_prdata;
    logic next_pslverr;

    // Send engine group
    rsfe_tx_state_t tx_state, next_tx_state;
    logic trig_q, next_trig_q;
    logic [7:0] tx_ptr, next_tx_ptr;
    logic [7:0] tx_left, next_tx_left;
    logic [7:0] tx_len, next_tx_len;
    logic [7:0] next_tx_data;
    logic next_tx_valid;
    logic tx_done_ev;
    logic tx_err_ev;
    logic tx_start;
    rsfe_pkg::rsfe_def_t cur_def;

    // Copy engine group
    rsfe_cp_state_t cp_state, next_cp_state;
    logic [7:0] cp_idx, next_cp_idx;
    logic [7:0] cp_len, next_cp_len;
    logic [7:0] cp_base, next_cp_base;
    logic rx_done_ev;
    logic rx_err_ev;

    // Receive framer outputs
    logic [7:0] rd_data;
    logic frame_done;
    logic [7:0] frame_len;
    logic fmt_bad;

    // Bus decode
    logic is_reg;
    logic mem_hit;
    logic def_hit;
    logic reg_hit;
    logic wr_acc;
    logic [7:0] mem_idx;
    logic [6:0] def_idx;

    // Storage write port
    logic mem_we;
    logic [7:0] mem_wa;
    logic [7:0] mem_wd;
    logic def_we;

    rsfe_rx #(
        .FRAME_MAX(rsfe_pkg::FRAME_MAX)
    ) u_rx (
        .clk(pclk),
        .rst_n(presetn),
        .enable(ctrl.rx_en),
        .fmt(rx_fmt),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rd_idx(cp_idx),
        .rd_data(rd_data),
        .frame_done(frame_done),
        .frame_len(frame_len),
        .fmt_bad(fmt_bad)
    );

    // Address decode; storage writes stall while the copy engine owns the port
    always_comb begin
        mem_idx = paddr[9:2];
        def_idx = paddr[8:2];
        is_reg = paddr[11:9] == rsfe_pkg::REGION_REG && paddr[1:0] == 2'h0;
        mem_hit = paddr[11:10] == rsfe_pkg::REGION_MEM && {1'b0, mem_idx} < MEM_LIMIT;
        def_hit = paddr[11:9] == rsfe_pkg::REGION_DEF && {1'b0, def_idx} < SLOT_LIMIT; // RL12
        reg_hit = is_reg && (paddr == rsfe_pkg::OFS_CTRL || paddr == rsfe_pkg::OFS_RX_FMT
            || paddr == rsfe_pkg::OFS_RX_BASE || paddr == rsfe_pkg::OFS_TX_STAT
            || paddr == rsfe_pkg::OFS_RX_STAT || paddr == rsfe_pkg::OFS_IRQ_STAT
            || paddr == rsfe_pkg::OFS_IRQ_MASK);
        pready = !(mem_hit && pwrite && cp_state == CP_COPY);
        wr_acc = psel && penable && pwrite && pready;
    end

    // Register next values, read capture in the setup cycle
    always_comb begin
        next_ctrl = ctrl;
        next_rx_fmt = rx_fmt;
        next_rx_base = rx_base;
        next_irq_mask = irq_mask;
        next_tx_stat = tx_stat;
        next_rx_stat = rx_stat;
        next_irq_stat = irq_stat;
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (wr_acc && reg_hit) begin
            case (paddr)
                rsfe_pkg::OFS_CTRL: next_ctrl = rsfe_pkg::rsfe_ctrl_t'(pwdata[15:0]);
                rsfe_pkg::OFS_RX_FMT: next_rx_fmt = rsfe_pkg::rsfe_fmt_t'(pwdata[15:0]); // RL5
                rsfe_pkg::OFS_RX_BASE: next_rx_base = pwdata[7:0];
                rsfe_pkg::OFS_TX_STAT: begin
                    next_tx_stat.done = tx_stat.done & ~pwdata[0];
                    next_tx_stat.err = tx_stat.err & ~pwdata[1];
                end
                rsfe_pkg::OFS_RX_STAT: begin
                    next_rx_stat.done = rx_stat.done & ~pwdata[0];
                    next_rx_stat.err = rx_stat.err & ~pwdata[1];
                end
                rsfe_pkg::OFS_IRQ_STAT: next_irq_stat = irq_stat & ~pwdata[rsfe_pkg::IRQ_W-1:0];
                rsfe_pkg::OFS_IRQ_MASK: next_irq_mask = pwdata[rsfe_pkg::IRQ_W-1:0];
                default: next_ctrl = ctrl;
            endcase
        end
        next_ctrl.pad = 6'h00;
        // Hardware events win over a clear in the same cycle
        if (tx_start) begin
            next_tx_stat.done = 1'b0;
            next_tx_stat.err = 1'b0;
        end
        if (tx_done_ev) begin
            next_tx_stat.done = 1'b1;
            next_tx_stat.len = tx_len;
        end
        if (tx_err_ev) begin
            next_tx_stat.err = 1'b1; // RL11
        end
        next_tx_stat.busy = next_tx_state == TX_SEND;
        if (rx_done_ev) begin
            next_rx_stat.done = 1'b1; // RL9
            next_rx_stat.len = cp_len; // RL10
        end
        if (rx_err_ev) begin
            next_rx_stat.err = 1'b1; // RL11
        end
        next_rx_stat.busy = next_cp_state == CP_COPY;
        next_irq_stat[rsfe_pkg::IRQ_TX_DONE] = next_irq_stat[rsfe_pkg::IRQ_TX_DONE] | tx_done_ev;
        next_irq_stat[rsfe_pkg::IRQ_RX_DONE] = next_irq_stat[rsfe_pkg::IRQ_RX_DONE] | rx_done_ev;
        next_irq_stat[rsfe_pkg::IRQ_ERR] = next_irq_stat[rsfe_pkg::IRQ_ERR] | tx_err_ev | rx_err_ev;
        if (psel && !penable) begin
            next_pslverr = !(reg_hit || mem_hit || def_hit);
            next_prdata = 32'h0000_0000;
            if (mem_hit) begin
                next_prdata[7:0] = mem[mem_idx[$clog2(MEM_BYTES > 1 ? MEM_BYTES : 2)-1:0]];
            end else if (def_hit) begin
                next_prdata[15:0] = defs[def_idx];
            end else if (reg_hit) begin
                case (paddr)
                    rsfe_pkg::OFS_CTRL: next_prdata[15:0] = ctrl;
                    rsfe_pkg::OFS_RX_FMT: next_prdata[15:0] = rx_fmt;
                    rsfe_pkg::OFS_RX_BASE: next_prdata[7:0] = rx_base;
                    rsfe_pkg::OFS_TX_STAT: next_prdata[15:0] = tx_stat;
                    rsfe_pkg::OFS_RX_STAT: next_prdata[15:0] = rx_stat;
                    rsfe_pkg::OFS_IRQ_STAT: next_prdata[rsfe_pkg::IRQ_W-1:0] = irq_stat;
                    rsfe_pkg::OFS_IRQ_MASK: next_prdata[rsfe_pkg::IRQ_W-1:0] = irq_mask;
                    default: next_prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // Register state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '0;
            rx_fmt <= rsfe_pkg::RX_FMT_RST;
            rx_base <= rsfe_pkg::RX_BASE_RST;
            tx_stat <= '0;
            rx_stat <= '0;
            irq_stat <= '0;
            irq_mask <= rsfe_pkg::IRQ_MASK_RST;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            rx_fmt <= next_rx_fmt;
            rx_base <= next_rx_base;
            tx_stat <= next_tx_stat;
            rx_stat <= next_rx_stat;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // Send engine: edge-started, walks the defined block byte by byte
    always_comb begin
        next_tx_state = tx_state;
        next_trig_q = ctrl.send;
        next_tx_ptr = tx_ptr;
        next_tx_left = tx_left;
        next_tx_len = tx_len;
        next_tx_data = tx_data;
        next_tx_valid = tx_valid;
        tx_done_ev = 1'b0;
        tx_err_ev = 1'b0;
        tx_start = 1'b0;
        cur_def = defs[ctrl.slot[$clog2(FRAME_SLOTS > 1 ? FRAME_SLOTS : 2)-1:0]]; // RL12
        case (tx_state)
            TX_IDLE: begin
                if (ctrl.send && !trig_q) begin // RL1 RL2
                    tx_start = 1'b1;
                    if ({1'b0, ctrl.slot} >= SLOT_LIMIT || cur_def.len == 8'h00
                        || {1'b0, cur_def.base} + {1'b0, cur_def.len} > MEM_LIMIT) begin
                        tx_err_ev = 1'b1; // RL11
                    end else begin
                        next_tx_ptr = cur_def.base; // RL3
                        next_tx_left = cur_def.len; // RL3
                        next_tx_len = cur_def.len;
                        next_tx_data = mem[cur_def.base];
                        next_tx_valid = 1'b1;
                        next_tx_state = TX_SEND;
                    end
                end
            end
            TX_SEND: begin
                if (tx_ready) begin
                    if (tx_left == 8'h01) begin
                        next_tx_valid = 1'b0;
                        next_tx_state = TX_IDLE;
                        tx_done_ev = 1'b1; // RL3
                    end else begin
                        next_tx_ptr = tx_ptr + 8'h01;
                        next_tx_left = tx_left - 8'h01;
                        next_tx_data = mem[tx_ptr + 8'h01];
                    end
                end
            end
            default: next_tx_state = TX_IDLE;
        endcase
    end

    // Send engine state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= TX_IDLE;
            trig_q <= 1'b0;
            tx_ptr <= 8'h00;
            tx_left <= 8'h00;
            tx_len <= 8'h00;
            tx_data <= 8'h00;
            tx_valid <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            trig_q <= next_trig_q;
            tx_ptr <= next_tx_ptr;
            tx_left <= next_tx_left;
            tx_len <= next_tx_len;
            tx_data <= next_tx_data;
            tx_valid <= next_tx_valid;
        end
    end

    // Copy engine: moves a closed frame into the destination area
    always_comb begin
        next_cp_state = cp_state;
        next_cp_idx = cp_idx;
        next_cp_len = cp_len;
        next_cp_base = cp_base;
        rx_done_ev = 1'b0;
        rx_err_ev = fmt_bad; // RL8
        case (cp_state)
            CP_IDLE: begin
                if (frame_done) begin
                    if ({1'b0, rx_base} + {1'b0, frame_len} > MEM_LIMIT) begin
                        rx_err_ev = 1'b1; // RL11 RL8
                    end else begin
                        next_cp_base = rx_base;
                        next_cp_len = frame_len;
                        next_cp_idx = 8'h00;
                        next_cp_state = CP_COPY; // RL4
                    end
                end
            end
            CP_COPY: begin
                if (frame_done) begin
                    rx_err_ev = 1'b1;
                end
                if (cp_idx == cp_len - 8'h01) begin
                    rx_done_ev = 1'b1; // RL9 RL10
                    next_cp_state = CP_IDLE;
                end else begin
                    next_cp_idx = cp_idx + 8'h01;
                end
            end
            default: next_cp_state = CP_IDLE;
        endcase
    end

    // Copy engine state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cp_state <= CP_IDLE;
            cp_idx <= 8'h00;
            cp_len <= 8'h00;
            cp_base <= 8'h00;
        end else begin
            cp_state <= next_cp_state;
            cp_idx <= next_cp_idx;
            cp_len <= next_cp_len;
            cp_base <= next_cp_base;
        end
    end

    // Storage write port: the copy engine has it, software waits
    always_comb begin
        mem_we = 1'b0;
        mem_wa = mem_idx;
        mem_wd = pwdata[7:0];
        def_we = wr_acc && def_hit;
        if (cp_state == CP_COPY) begin
            mem_we = 1'b1;
            mem_wa = cp_base + cp_idx; // RL4
            mem_wd = rd_data;
        end else if (wr_acc && mem_hit) begin
            mem_we = 1'b1;
        end
    end

    // Storage and definition table arrays
    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
        if (def_we) begin
            defs[def_idx] <= rsfe_pkg::rsfe_def_t'(pwdata[15:0]);
        end
    end

endmodule

// *** test/rsfe_top_assertions.sv ***
// Port-level checker of the frame engine
module rsfe_top_assertions #(
    parameter int unsigned MEM_BYTES = rsfe_pkg::MEM_BYTES,
    parameter int unsigned FRAME_SLOTS = rsfe_pkg::FRAME_SLOTS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Outgoing byte stream and interrupt
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    send_rise_a: assert property ($rose(tx_valid) |-> $past(psel && penable && pwrite && paddr == rsfe_pkg::OFS_CTRL
        && pwdata[0], 2) || $past(tx_valid, 2)) else $error("send without trigger");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx byte changed");
    ready_zero_a: assert property (psel && penable && !(pwrite && paddr[11:10] == 2'h1) |-> pready)
        else $error("access delayed");
    stall_bound_a: assert property (psel && penable && !pready |-> ##[1:260] pready)
        else $error("stall too long");
    unmapped_err_a: assert property (psel && !penable && (paddr[11] || (paddr[11:9] == 3'h0 && paddr > 12'h018))
        |=> pslverr) else $error("no error on unmapped");
    mapped_ok_a: assert property (psel && !penable && (paddr[11:10] == 2'h1 || paddr == rsfe_pkg::OFS_CTRL)
        |=> !pslverr) else $error("mapped access refused");
    rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("prdata changed");
    reset_quiet_a: assert property ($rose(presetn) |-> !tx_valid && !irq)
        else $error("active after reset");
    cover property ($rose(tx_valid));
    cover property ($rose(irq));
    cover property (psel && penable && !pready);
endmodule

bind rsfe_top rsfe_top_assertions #(.MEM_BYTES(MEM_BYTES), .FRAME_SLOTS(FRAME_SLOTS)) u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .irq(irq));

// *** test/rsfe_link_model.sv ***
// Far-side serial device: random stalls out, queued bytes in
module rsfe_link_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bytes from the engine
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    // Bytes to the engine
    output logic [7:0] rx_data,
    output logic rx_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];
    logic [7:0] pend[$];
    // Take sent bytes, play back queued ones
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= 8'hA5;
        end else begin
            if (tx_valid && tx_ready) got.push_back(tx_data);
            tx_ready <= 1'($urandom_range(1, 0));
            rx_valid <= pend.size() > 0;
            rx_data <= pend.size() > 0 ? pend.pop_front() : ~rx_data; // No stale byte when idle
        end
    end
endmodule

// *** test/tb.sv ***
// Self-checking bench of the raw serial frame engine
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_valid, tx_ready, rx_valid, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] tx_data, rx_data, b;
    logic [7:0] exp[$];
    int fails, tests_run, n;
    // Clock of 40 ns
    always #20 pclk = ~pclk;
    rsfe_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .irq(irq));
    rsfe_link_model u_link (.pclk(pclk), .presetn(presetn), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
    // Verdict and end of run
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
        tests_run++;
        if (s !== x) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, x, s);
        end
    endtask
    // One APB transfer, bounded wait
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (int k = 0; k < 300; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (pready !== 1'b1) begin
            fails++;
            wrap_up();
        end
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    // Poll until status bit i is set
    task automatic poll(input logic [11:0] a, input int i);
        for (int k = 0; k < 200; k++) begin
            apb(1'b0, a, 32'h0);
            if (q[i] === 1'b1) return;
        end
        fails++;
        wrap_up();
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(32'h1B9E));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, rsfe_pkg::OFS_RX_FMT, 32'h0);
        chk("rx_fmt", 32'h0103, q);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        apb(1'b1, rsfe_pkg::OFS_IRQ_MASK, 32'h7);
        // Sends from slot 5 and slot 127
        for (int s = 0; s < 2; s++) begin
            n = $urandom_range(8, 1);
            exp.delete();
            for (int i = 0; i < n; i++) begin
                exp.push_back(8'($urandom));
                apb(1'b1, 12'h400 + 12'(4 * (16 + 32 * s + i)), {24'h0, exp[i]});
            end
            apb(1'b1, 12'h200 + 12'(4 * (s ? 127 : 5)), 32'(((16 + 32 * s) << 8) + n));
            apb(1'b1, rsfe_pkg::OFS_CTRL, 32'h0);
            apb(1'b1, rsfe_pkg::OFS_CTRL, 32'(((s ? 127 : 5) << 8) + 1));
            poll(rsfe_pkg::OFS_TX_STAT, 0);
            chk("tx_len", 32'(n), {24'h0, q[15:8]});
            chk("tx_count", 32'(n), 32'(u_link.got.size()));
            for (int i = 0; i < n; i++) chk("tx_byte", {24'h0, exp[i]}, {24'h0, u_link.got.pop_front()});
            chk("irq_tx", 32'h1, {31'h0, irq});
            apb(1'b1, rsfe_pkg::OFS_IRQ_STAT, 32'h7);
            apb(1'b1, rsfe_pkg::OFS_TX_STAT, 32'h3);
            chk("irq_clr", 32'h0, {31'h0, irq});
        end
        // Held trigger, then an oversized definition
        apb(1'b1, rsfe_pkg::OFS_CTRL, 32'h7F01);
        repeat (20) @(posedge pclk);
        chk("held", 32'h0, 32'(u_link.got.size()));
        apb(1'b1, 12'h20C, 32'hFA0A);
        apb(1'b1, rsfe_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, rsfe_pkg::OFS_CTRL, 32'h0301);
        poll(rsfe_pkg::OFS_TX_STAT, 1);
        chk("bad_def", 32'h0, 32'(u_link.got.size()));
        apb(1'b1, rsfe_pkg::OFS_IRQ_STAT, 32'h7);
        apb(1'b1, rsfe_pkg::OFS_IRQ_MASK, 32'h5);
        apb(1'b1, rsfe_pkg::OFS_RX_BASE, 32'h40);
        apb(1'b1, rsfe_pkg::OFS_CTRL, 32'h2);
        // Count frame, then terminator frames
        for (int m = 0; m < 3; m++) begin
            exp.delete();
            apb(1'b1, rsfe_pkg::OFS_RX_FMT, m ? 32'h0103 : 32'h0004);
            for (int i = 0; i < 4; i++) exp.push_back((m && i == 3) ? 8'h03 : 8'($urandom) | 8'h80);
            foreach (exp[i]) u_link.pend.push_back(exp[i]);
            poll(rsfe_pkg::OFS_RX_STAT, 0);
            chk("rx_len", 32'h4, {24'h0, q[15:8]});
            for (int i = 0; i < 4; i++) begin
                apb(1'b0, 12'h400 + 12'(4 * (64 + i)), 32'h0);
                chk("rx_byte", {24'h0, exp[i]}, q);
            end
            apb(1'b1, rsfe_pkg::OFS_RX_STAT, 32'h3);
        end
        chk("irq_mask", 32'h0, {31'h0, irq});
        apb(1'b1, rsfe_pkg::OFS_IRQ_MASK, 32'h7);
        chk("irq_rx", 32'h1, {31'h0, irq});
        // Bad format, then destination overflow
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, rsfe_pkg::OFS_RX_FMT, k ? 32'h0003 : 32'h0200);
            apb(1'b1, rsfe_pkg::OFS_RX_BASE, k ? 32'hFE : 32'h40);
            repeat (3) u_link.pend.push_back(8'($urandom));
            repeat (12) @(posedge pclk);
            apb(1'b0, rsfe_pkg::OFS_RX_STAT, 32'h0);
            chk("rx_err", 32'h2, {30'h0, q[1:0]});
            apb(1'b1, rsfe_pkg::OFS_RX_STAT, 32'h3);
        end
        wrap_up();
    end
endmodule
